// *** hw/psq_pkg.sv ***
// Summary of operation
// - idle-to-run start forces run state
// - early return to idle forces stop
// - stop-at-end pattern stops when soak done
// - completion flashes end and raises end output
// - run-to-idle after completion clears end
// - key run while idle starts plain control
// - start while running keeps run state
// - key stop keeps soak timing inside band
// - key run leaves soak count as it stands
// - calculated output clamped between limits
// - stop and error values bypass limits; manual bypasses them unless limit enabled
// - manual limit enable clamps manual value
// - one limit pair for heat/cool output
// - stop value only when enable set
// - heat/cool: negative to cooling, positive to heating
// - stop value resets to zero
// - stop value range depends on control type
// - valve code drives open/close outputs
// - valve stop code resets to hold
// - direct setting stop value is opening target
// - pot error: open at 100, close at 0
// - priority manual, then stop, then error
// - soak advances only inside wait band, or anywhere with band off
// - pattern selects stop/continue, off disables
// - event-assigned start ignores key changes
`default_nettype none
package psq_pkg;

    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned SECOND_MS   = 1000;
    localparam int unsigned FLASH_MS    = 500;
    localparam int unsigned SEC_CYCLES  = SECOND_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
    localparam logic [11:0] SEC_PER_MIN  = 12'h03C;
    localparam logic [11:0] SEC_PER_HOUR = 12'hE10;

    // outputs are signed tenths of a percent
    localparam int          MV_W          = 12;
    localparam logic [11:0] STOP_MV_RST   = 12'h000;
    localparam logic [11:0] STD_MV_MIN    = 12'hFCE;
    localparam logic [11:0] STD_MV_MAX    = 12'h41A;
    localparam logic [11:0] HC_MV_MIN     = 12'hBE6;
    localparam logic [11:0] HC_MV_MAX     = 12'h41A;
    localparam logic [11:0] VALVE_FULL_MV = 12'h3E8;
    localparam logic [11:0] VALVE_ZERO_MV = 12'h000;
    localparam logic [13:0] SOAK_CNT_RST  = 14'h0000;

    typedef enum logic {
        program_idle_code = 1'b0,
        program_run_code  = 1'b1
    } psq_prog_t;

    typedef enum logic [1:0] {
        pattern_off             = 2'b00,
        stop_at_end_pattern     = 2'b01,
        continue_at_end_pattern = 2'b10
    } psq_pattern_t;

    typedef enum logic [1:0] {
        valve_hold_code  = 2'b00,
        valve_open_code  = 2'b01,
        valve_close_code = 2'b10
    } psq_valve_code_t;

    typedef enum logic [1:0] {
        unit_second = 2'b00,
        unit_minute = 2'b01,
        unit_hour   = 2'b10
    } psq_unit_t;

    typedef struct packed {
        logic open;
        logic close;
    } psq_valve_t;

endpackage
`default_nettype wire

// *** hw/psq_clamp.sv ***
`timescale 1ns/1ps
`default_nettype none
module psq_clamp #(
    parameter int W = 12
) (
    input  wire logic signed [W-1:0] val_in,
    input  wire logic signed [W-1:0] lo_in,
    input  wire logic signed [W-1:0] hi_in,
    output logic signed [W-1:0]      val_out
);
    always_comb begin
        if (val_in < lo_in) begin
            val_out = lo_in;
        end else if (val_in > hi_in) begin
            val_out = hi_in;
        end else begin
            val_out = val_in;
        end
    end
endmodule
`default_nettype wire

// *** hw/psq_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer #(
    parameter int unsigned SEC_CYCLES   = psq_pkg::SEC_CYCLES,
    parameter int unsigned FLASH_CYCLES = psq_pkg::FLASH_CYCLES,
    parameter int          MV_W         = psq_pkg::MV_W
) (
    input  wire logic                    CLK_IN,
    input  wire logic                    RESET_IN,
    input  wire logic [1:0]              PATTERN_IN,
    input  wire logic                    START_ON_EVENT_IN,
    input  wire logic                    EVENT_START_IN,
    input  wire logic                    KEY_PRG_START_IN,
    input  wire logic                    KEY_PRG_RESET_IN,
    input  wire logic                    KEY_RUN_IN,
    input  wire logic                    KEY_STOP_IN,
    input  wire logic [13:0]             SOAK_TIME_IN,
    input  wire logic [1:0]              SOAK_UNIT_IN,
    input  wire logic                    WAIT_BAND_OFF_IN,
    input  wire logic [15:0]             WAIT_BAND_IN,
    input  wire logic signed [15:0]      PV_IN,
    input  wire logic signed [15:0]      SP_IN,
    input  wire logic                    HEAT_COOL_IN,
    input  wire logic                    FLOATING_IN,
    input  wire logic                    DIRECT_SET_IN,
    input  wire logic                    POT_ERROR_IN,
    input  wire logic                    PV_ERROR_IN,
    input  wire logic                    STOP_ERR_EN_IN,
    input  wire logic                    MANUAL_MODE_IN,
    input  wire logic                    MANUAL_LIMIT_EN_IN,
    input  wire logic signed [MV_W-1:0]  MANUAL_MV_IN,
    input  wire logic signed [MV_W-1:0]  CALC_MV_IN,
    input  wire logic signed [MV_W-1:0]  ERROR_MV_IN,
    input  wire logic [1:0]              ERROR_VALVE_CODE_IN,
    input  wire logic signed [MV_W-1:0]  MV_LOW_LIM_IN,
    input  wire logic signed [MV_W-1:0]  MV_HIGH_LIM_IN,
    input  wire logic signed [MV_W-1:0]  VALVE_POS_IN,
    input  wire logic                    STOP_WR_IN,
    input  wire logic signed [MV_W-1:0]  STOP_MV_IN,
    input  wire logic [1:0]              STOP_VALVE_CODE_IN,
    output logic                         PROGRAM_START_OUT,
    output logic                         RUN_OUT,
    output logic                         END_OUT,
    output logic                         END_FLASH_OUT,
    output logic [13:0]                  SOAK_REMAIN_OUT,
    output logic signed [MV_W-1:0]       STOP_MV_OUT,
    output logic signed [MV_W-1:0]       MV_OUT,
    output logic [MV_W-1:0]              HEAT_MV_OUT,
    output logic [MV_W-1:0]              COOL_MV_OUT,
    output psq_pkg::psq_valve_t          VALVE_OUT
);
    localparam int SW = $clog2(SEC_CYCLES + 1);
    localparam int FW = $clog2(FLASH_CYCLES + 1);

    logic                   prog_ff;
    logic                   nxt_prog;
    logic                   run_ff;
    logic                   done_ff;
    logic                   flash_ff;
    logic [13:0]            soak_cnt_ff;
    logic [SW-1:0]          sec_div_ff;
    logic [FW-1:0]          flash_div_ff;
    logic [11:0]            unit_cnt_ff;
    logic [11:0]            unit_len;
    logic signed [MV_W-1:0] stop_mv_ff;
    logic [1:0]             stop_code_ff;
    logic signed [MV_W-1:0] mv_ff;
    logic [MV_W-1:0]        heat_ff;
    logic [MV_W-1:0]        cool_ff;
    psq_pkg::psq_valve_t    valve_ff;
    logic                   prog_enabled;
    logic                   start_edge;
    logic                   reset_edge;
    logic                   sec_tick;
    logic                   unit_tick;
    logic                   in_band;
    logic                   soak_reached;
    logic signed [16:0]     pv_diff;
    logic [16:0]            pv_dist;
    logic signed [MV_W-1:0] calc_lim;
    logic signed [MV_W-1:0] man_lim;
    logic signed [MV_W-1:0] stop_wr_lim;
    logic signed [MV_W-1:0] range_lo;
    logic signed [MV_W-1:0] range_hi;
    logic signed [MV_W-1:0] nxt_mv;
    logic                   use_stop;
    logic                   use_error;
    logic signed [MV_W-1:0] fixed_mv;
    logic [1:0]             fixed_code;
    psq_pkg::psq_valve_t    nxt_valve;

    assign prog_enabled = PATTERN_IN != psq_pkg::pattern_off;

    // event assignment makes the start setting a mirror of the event line
    always_comb begin
        nxt_prog = prog_ff;
        if (!prog_enabled) begin
            nxt_prog = psq_pkg::program_idle_code;
        end else if (START_ON_EVENT_IN) begin
            nxt_prog = EVENT_START_IN;
        end else if (KEY_PRG_START_IN) begin
            nxt_prog = psq_pkg::program_run_code;
        end else if (KEY_PRG_RESET_IN) begin
            nxt_prog = psq_pkg::program_idle_code;
        end
    end

    assign start_edge   = (prog_ff == psq_pkg::program_idle_code) &&
                          (nxt_prog == psq_pkg::program_run_code);
    assign reset_edge   = (prog_ff == psq_pkg::program_run_code) &&
                          (nxt_prog == psq_pkg::program_idle_code);
    assign soak_reached = prog_ff && !done_ff && (soak_cnt_ff >= SOAK_TIME_IN);

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            prog_ff <= psq_pkg::program_idle_code;
        end else begin
            prog_ff <= nxt_prog;
        end
    end

    // program events outrank key run/stop in the same cycle
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            run_ff <= 1'b0;
        end else if (start_edge) begin
            run_ff <= 1'b1;
        end else if (reset_edge && !done_ff) begin
            run_ff <= 1'b0;
        end else if (soak_reached && PATTERN_IN == psq_pkg::stop_at_end_pattern) begin
            run_ff <= 1'b0;
        end else if (KEY_RUN_IN) begin
            run_ff <= 1'b1;
        end else if (KEY_STOP_IN) begin
            run_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            done_ff <= 1'b0;
        end else if (start_edge || reset_edge || !prog_enabled) begin
            done_ff <= 1'b0;
        end else if (soak_reached) begin
            done_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            sec_div_ff <= '0;
        end else if (sec_tick) begin
            sec_div_ff <= '0;
        end else begin
            sec_div_ff <= sec_div_ff + 1'b1;
        end
    end
    assign sec_tick = sec_div_ff == SW'(SEC_CYCLES - 1);

    always_comb begin
        unique case (SOAK_UNIT_IN)
            psq_pkg::unit_second: unit_len = 12'h001;
            psq_pkg::unit_hour:   unit_len = psq_pkg::SEC_PER_HOUR;
            default:              unit_len = psq_pkg::SEC_PER_MIN;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            unit_cnt_ff <= 12'h000;
        end else if (start_edge || unit_tick) begin
            unit_cnt_ff <= 12'h000;
        end else if (sec_tick) begin
            unit_cnt_ff <= unit_cnt_ff + 12'h001;
        end
    end
    assign unit_tick = sec_tick && (unit_cnt_ff >= unit_len - 12'h001);

    assign pv_diff = 17'(PV_IN) - 17'(SP_IN);
    assign pv_dist = pv_diff[16] ? 17'(-pv_diff) : pv_diff;
    assign in_band = WAIT_BAND_OFF_IN || (pv_dist <= {1'b0, WAIT_BAND_IN});

    // run state is not consulted: soak keeps timing while stopped by key
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            soak_cnt_ff <= psq_pkg::SOAK_CNT_RST;
        end else if (start_edge) begin
            soak_cnt_ff <= psq_pkg::SOAK_CNT_RST;
        end else if (prog_ff && !done_ff && in_band && unit_tick &&
                     soak_cnt_ff < SOAK_TIME_IN) begin
            soak_cnt_ff <= soak_cnt_ff + 14'h0001;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            flash_div_ff <= '0;
            flash_ff     <= 1'b0;
        end else if (!done_ff) begin
            flash_div_ff <= '0;
            flash_ff     <= 1'b0;
        end else if (flash_div_ff == FW'(FLASH_CYCLES - 1)) begin
            flash_div_ff <= '0;
            flash_ff     <= !flash_ff;
        end else begin
            flash_div_ff <= flash_div_ff + 1'b1;
        end
    end

    assign range_lo = HEAT_COOL_IN ? psq_pkg::HC_MV_MIN : psq_pkg::STD_MV_MIN;
    assign range_hi = HEAT_COOL_IN ? psq_pkg::HC_MV_MAX : psq_pkg::STD_MV_MAX;

    psq_clamp #(.W(MV_W)) u_stop_range (
        .val_in  (STOP_MV_IN),
        .lo_in   (range_lo),
        .hi_in   (range_hi),
        .val_out (stop_wr_lim)
    );

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            stop_mv_ff   <= psq_pkg::STOP_MV_RST;
            stop_code_ff <= psq_pkg::valve_hold_code;
        end else if (STOP_WR_IN) begin
            stop_mv_ff   <= stop_wr_lim;
            stop_code_ff <= STOP_VALVE_CODE_IN;
        end
    end

    psq_clamp #(.W(MV_W)) u_calc_lim (
        .val_in  (CALC_MV_IN),
        .lo_in   (MV_LOW_LIM_IN),
        .hi_in   (MV_HIGH_LIM_IN),
        .val_out (calc_lim)
    );

    psq_clamp #(.W(MV_W)) u_man_lim (
        .val_in  (MANUAL_MV_IN),
        .lo_in   (MV_LOW_LIM_IN),
        .hi_in   (MV_HIGH_LIM_IN),
        .val_out (man_lim)
    );

    assign use_stop   = !MANUAL_MODE_IN && !run_ff && STOP_ERR_EN_IN;
    assign use_error  = !MANUAL_MODE_IN && !use_stop && PV_ERROR_IN && STOP_ERR_EN_IN;
    assign fixed_mv   = use_stop ? stop_mv_ff : ERROR_MV_IN;
    assign fixed_code = use_stop ? stop_code_ff : ERROR_VALVE_CODE_IN;

    always_comb begin
        if (MANUAL_MODE_IN) begin
            nxt_mv = MANUAL_LIMIT_EN_IN ? man_lim : MANUAL_MV_IN;
        end else if (use_stop || use_error) begin
            nxt_mv = fixed_mv;
        end else begin
            nxt_mv = calc_lim;
        end
    end

    // valve drive; fixed values on a code model bypass the position loop
    always_comb begin
        nxt_valve = '0;
        if ((use_stop || use_error) && (FLOATING_IN || !DIRECT_SET_IN)) begin
            nxt_valve.open  = fixed_code == psq_pkg::valve_open_code;
            nxt_valve.close = fixed_code == psq_pkg::valve_close_code;
        end else if (POT_ERROR_IN) begin
            // limits are stored unsigned: compare signed or negatives read as huge
            nxt_valve.open  = nxt_mv >= $signed(psq_pkg::VALVE_FULL_MV);
            nxt_valve.close = nxt_mv <= $signed(psq_pkg::VALVE_ZERO_MV);
        end else if (!FLOATING_IN) begin
            nxt_valve.open  = nxt_mv > VALVE_POS_IN;
            nxt_valve.close = nxt_mv < VALVE_POS_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            mv_ff    <= '0;
            heat_ff  <= '0;
            cool_ff  <= '0;
            valve_ff <= '0;
        end else begin
            mv_ff    <= nxt_mv;
            valve_ff <= nxt_valve;
            if (HEAT_COOL_IN && nxt_mv[MV_W-1]) begin
                heat_ff <= '0;
                cool_ff <= MV_W'(-nxt_mv);
            end else begin
                heat_ff <= nxt_mv[MV_W-1] ? '0 : nxt_mv;
                cool_ff <= '0;
            end
        end
    end

    assign PROGRAM_START_OUT = prog_ff;
    assign RUN_OUT           = run_ff;
    assign END_OUT           = done_ff;
    assign END_FLASH_OUT     = flash_ff;
    assign SOAK_REMAIN_OUT   = (soak_cnt_ff >= SOAK_TIME_IN) ? 14'h0000 :
                               SOAK_TIME_IN - soak_cnt_ff;
    assign STOP_MV_OUT       = stop_mv_ff;
    assign MV_OUT            = mv_ff;
    assign HEAT_MV_OUT       = heat_ff;
    assign COOL_MV_OUT       = cool_ff;
    assign VALVE_OUT         = valve_ff;
endmodule
`default_nettype wire

// *** tb/psq_valve_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module psq_valve_model (
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire psq_pkg::psq_valve_t valve_in,
    output logic signed [11:0]       pos_out
);
    // travel of 1.0 percent a cycle; both coils on means the motor stalls
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pos_out <= 12'h000;
        end else if (valve_in.open && !valve_in.close && pos_out < 12'sh3E8) begin
            pos_out <= pos_out + 12'sh00A;
        end else if (valve_in.close && !valve_in.open && pos_out > 12'sh000) begin
            pos_out <= pos_out - 12'sh00A;
        end
    end
endmodule
`default_nettype wire

// *** tb/psq_seq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module psq_seq_checker (
    input wire logic               CLK_IN,
    input wire logic               RESET_IN,
    input wire logic [1:0]         PATTERN_IN,
    input wire logic               START_ON_EVENT_IN,
    input wire logic               EVENT_START_IN,
    input wire logic               HEAT_COOL_IN,
    input wire logic               PV_ERROR_IN,
    input wire logic               STOP_ERR_EN_IN,
    input wire logic               MANUAL_MODE_IN,
    input wire logic               MANUAL_LIMIT_EN_IN,
    input wire logic signed [11:0] MANUAL_MV_IN,
    input wire logic signed [11:0] MV_LOW_LIM_IN,
    input wire logic signed [11:0] MV_HIGH_LIM_IN,
    input wire logic               PROGRAM_START_OUT,
    input wire logic               RUN_OUT,
    input wire logic               END_OUT,
    input wire logic               END_FLASH_OUT,
    input wire logic signed [11:0] STOP_MV_OUT,
    input wire logic signed [11:0] MV_OUT,
    input wire logic [11:0]        HEAT_MV_OUT,
    input wire logic [11:0]        COOL_MV_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    chk_start_run: assert property ($rose(PROGRAM_START_OUT) |-> RUN_OUT)
        else $error("start did not force run");
    chk_early_stop: assert property ($fell(PROGRAM_START_OUT) && !$past(END_OUT) |-> !RUN_OUT)
        else $error("early reset did not force stop");
    chk_end_clear: assert property ($fell(PROGRAM_START_OUT) |-> !END_OUT)
        else $error("end not cleared on return to idle");
    chk_stop_end: assert property ($rose(END_OUT) && $past(PATTERN_IN) == 2'h1 |-> !RUN_OUT)
        else $error("stop pattern left run at end");
    chk_pattern_off: assert property (PATTERN_IN == 2'h0 |=> !PROGRAM_START_OUT && !END_OUT)
        else $error("program active with pattern off");
    chk_event_follow: assert property (START_ON_EVENT_IN && PATTERN_IN != 2'h0
        |=> PROGRAM_START_OUT == $past(EVENT_START_IN)) else $error("start not following event");
    chk_flash_idle: assert property (!END_OUT [*2] |-> !END_FLASH_OUT)
        else $error("end flashing without end");
    chk_manual_raw: assert property (MANUAL_MODE_IN && !MANUAL_LIMIT_EN_IN
        |=> MV_OUT == $past(MANUAL_MV_IN)) else $error("manual value not selected");
    chk_stop_value: assert property (!MANUAL_MODE_IN && !RUN_OUT && STOP_ERR_EN_IN
        ##1 $stable(RUN_OUT) && $stable(STOP_MV_OUT) |-> MV_OUT == STOP_MV_OUT)
        else $error("stop value not selected");
    chk_calc_limit: assert property (!MANUAL_MODE_IN && !(STOP_ERR_EN_IN && (!RUN_OUT || PV_ERROR_IN))
        ##1 $stable(RUN_OUT) |-> MV_OUT >= $past(MV_LOW_LIM_IN) && MV_OUT <= $past(MV_HIGH_LIM_IN))
        else $error("calculated output outside limits");
    chk_cool_side: assert property (HEAT_COOL_IN ##1 $stable(HEAT_COOL_IN) && MV_OUT < 0
        |-> COOL_MV_OUT == -MV_OUT && HEAT_MV_OUT == 12'h000) else $error("negative value not on cooling");
endmodule
bind psq_sequencer psq_seq_checker chk_i (.*);
`default_nettype wire

// *** tb/tb_program_sequencer_mv_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_program_sequencer_mv_select;
    logic               CLK_IN, RESET_IN, START_ON_EVENT_IN, EVENT_START_IN, WAIT_BAND_OFF_IN;
    logic               HEAT_COOL_IN, FLOATING_IN, DIRECT_SET_IN, POT_ERROR_IN, PV_ERROR_IN;
    logic               STOP_ERR_EN_IN, MANUAL_MODE_IN, MANUAL_LIMIT_EN_IN, STOP_WR_IN;
    logic [1:0]         PATTERN_IN, SOAK_UNIT_IN, ERROR_VALVE_CODE_IN, STOP_VALVE_CODE_IN;
    logic [3:0]         keys;
    wire logic          KEY_PRG_START_IN, KEY_PRG_RESET_IN, KEY_RUN_IN, KEY_STOP_IN;
    logic [13:0]        SOAK_TIME_IN, SOAK_REMAIN_OUT;
    logic [15:0]        WAIT_BAND_IN;
    logic signed [15:0] PV_IN, SP_IN;
    logic signed [11:0] MANUAL_MV_IN, CALC_MV_IN, ERROR_MV_IN, MV_LOW_LIM_IN, MV_HIGH_LIM_IN;
    logic signed [11:0] VALVE_POS_IN, STOP_MV_IN, STOP_MV_OUT, MV_OUT;
    logic               PROGRAM_START_OUT, RUN_OUT, END_OUT, END_FLASH_OUT;
    logic [11:0]        HEAT_MV_OUT, COOL_MV_OUT;
    psq_pkg::psq_valve_t VALVE_OUT;
    int                 n_fail, check_count, n, r;
    int                 cyc = 0;
    logic [11:0]        sv[4] = '{12'h3E8, 12'h000, 12'h1F4, 12'hFCE};
    logic [1:0]         ev[4] = '{2'h2, 2'h1, 2'h0, 2'h1};

    assign {KEY_PRG_START_IN, KEY_PRG_RESET_IN, KEY_RUN_IN, KEY_STOP_IN} = keys;
    // short second and flash period keep the soak tests to a few hundred cycles
    psq_sequencer #(.SEC_CYCLES(4), .FLASH_CYCLES(2)) DUT (.*);
    psq_valve_model act (.clk_in(CLK_IN), .reset_in(RESET_IN), .valve_in(VALVE_OUT),
                         .pos_out(VALVE_POS_IN));

    initial begin
        CLK_IN = 1'b0;
        forever #20 CLK_IN = ~CLK_IN;
    end

    always @(posedge CLK_IN) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK_IN);
        #1;
    endtask
    task automatic key(input logic [3:0] k);
        @(posedge CLK_IN) keys <= k;
        @(posedge CLK_IN) keys <= 4'h0;
        #1;
    endtask
    task automatic wr(input logic [11:0] v, input logic [1:0] c);
        @(posedge CLK_IN);
        STOP_WR_IN <= 1'b1;
        STOP_MV_IN <= v;
        STOP_VALVE_CODE_IN <= c;
        @(posedge CLK_IN) STOP_WR_IN <= 1'b0;
        tick(2);
    endtask
    task automatic wait_end(input int lim);
        n = 0;
        while (END_OUT !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    initial begin
        {START_ON_EVENT_IN, EVENT_START_IN, WAIT_BAND_OFF_IN, HEAT_COOL_IN, DIRECT_SET_IN} = '0;
        {POT_ERROR_IN, PV_ERROR_IN, MANUAL_MODE_IN, MANUAL_LIMIT_EN_IN, STOP_WR_IN, keys} = '0;
        {SOAK_UNIT_IN, ERROR_VALVE_CODE_IN, STOP_VALVE_CODE_IN, STOP_MV_IN} = '0;
        {FLOATING_IN, STOP_ERR_EN_IN, RESET_IN} = 3'h7;
        {n_fail, check_count} = '0;
        PATTERN_IN = 2'h1;
        SOAK_TIME_IN = 14'h0003;
        WAIT_BAND_IN = 16'h000A;
        {SP_IN, PV_IN} = {16'h0064, 16'h0064};
        {CALC_MV_IN, MANUAL_MV_IN, ERROR_MV_IN} = {12'h4B0, 12'h44C, 12'h3FC};
        {MV_LOW_LIM_IN, MV_HIGH_LIM_IN} = {12'hFCE, 12'h3E8};
        tick(2);
        @(posedge CLK_IN) RESET_IN <= 1'b0;
        tick(1);
        chk(STOP_MV_OUT, 12'h000);
        chk(VALVE_OUT, 12'h000);
        key(4'h8);
        chk(RUN_OUT, 12'h001);
        tick(4);
        key(4'h4);
        chk(RUN_OUT, 12'h000);
        // restart far outside the band: soak must not move
        @(posedge CLK_IN) PV_IN <= 16'h00C8;
        key(4'h8);
        chk(SOAK_REMAIN_OUT[11:0], 12'h003);
        tick(30);
        chk(SOAK_REMAIN_OUT[11:0], 12'h003);
        @(posedge CLK_IN) PV_IN <= 16'h0069;
        wait_end(40);
        chk(12'(n >= 8 && n <= 16), 12'h001);
        chk(RUN_OUT, 12'h000);
        chk(END_OUT, 12'h001);
        n = 0;
        repeat (4) begin
            tick(1);
            n += END_FLASH_OUT;
        end
        chk(12'(n), 12'h002);
        key(4'h4);
        chk(END_OUT, 12'h000);
        @(posedge CLK_IN) {PATTERN_IN, SOAK_TIME_IN} <= {2'h2, 14'h0005};
        key(4'h2);
        chk({PROGRAM_START_OUT, RUN_OUT}, 12'h001);
        key(4'h8);
        chk(RUN_OUT, 12'h001);
        key(4'h1);
        tick(12);
        @(posedge CLK_IN) PV_IN <= 16'h00C8;
        tick(2);
        r = SOAK_REMAIN_OUT;
        chk(12'(r <= 3), 12'h001);
        key(4'h2);
        tick(20);
        chk(SOAK_REMAIN_OUT[11:0], 12'(r));
        // band off: timer runs though the value stays far outside
        @(posedge CLK_IN) WAIT_BAND_OFF_IN <= 1'b1;
        wait_end(40);
        chk(12'(n <= r * 4 + 3), 12'h001);
        chk({END_OUT, RUN_OUT}, 12'h003);
        key(4'h4);
        @(posedge CLK_IN) PATTERN_IN <= 2'h0;
        key(4'h8);
        chk(PROGRAM_START_OUT, 12'h000);
        @(posedge CLK_IN) {PATTERN_IN, START_ON_EVENT_IN} <= 3'h3;
        key(4'h8);
        chk(PROGRAM_START_OUT, 12'h000);
        @(posedge CLK_IN) EVENT_START_IN <= 1'b1;
        tick(2);
        chk(PROGRAM_START_OUT, 12'h001);
        // event line returns to idle before the soak ends
        @(posedge CLK_IN) EVENT_START_IN <= 1'b0;
        tick(2);
        chk(RUN_OUT, 12'h000);
        key(4'h2);
        tick(1);
        chk(MV_OUT, 12'h3E8);
        @(posedge CLK_IN) CALC_MV_IN <= 12'hED4;
        tick(2);
        chk(MV_OUT, 12'hFCE);
        @(posedge CLK_IN) MANUAL_MODE_IN <= 1'b1;
        tick(2);
        chk(MV_OUT, 12'h44C);
        @(posedge CLK_IN) MANUAL_LIMIT_EN_IN <= 1'b1;
        tick(2);
        chk(MV_OUT, 12'h3E8);
        @(posedge CLK_IN) {MANUAL_MODE_IN, PV_ERROR_IN} <= 2'h1;
        tick(2);
        chk(MV_OUT, 12'h3FC);
        key(4'h1);
        wr(12'h7D0, 2'h0);
        chk(STOP_MV_OUT, 12'h41A);
        chk(MV_OUT, 12'h41A);
        @(posedge CLK_IN) {STOP_ERR_EN_IN, PV_ERROR_IN} <= 2'h0;
        tick(2);
        chk(MV_OUT, 12'hFCE);
        @(posedge CLK_IN) {STOP_ERR_EN_IN, HEAT_COOL_IN} <= 2'h3;
        wr(12'h830, 2'h0);
        chk(MV_OUT, 12'hBE6);
        chk(COOL_MV_OUT, 12'h41A);
        chk(HEAT_MV_OUT, 12'h000);
        for (int i = 0; i < 3; i++) begin
            wr(12'h000, 2'(i));
            chk(VALVE_OUT, 12'({i[0], i[1]}));
        end
        @(posedge CLK_IN) {FLOATING_IN, DIRECT_SET_IN, POT_ERROR_IN, HEAT_COOL_IN} <= 4'h6;
        for (int i = 0; i < 4; i++) begin
            wr(sv[i], 2'h0);
            chk(VALVE_OUT, 12'(ev[i]));
        end
        @(posedge CLK_IN) POT_ERROR_IN <= 1'b0;
        wr(12'h1F4, 2'h0);
        tick(80);
        chk(12'(VALVE_POS_IN >= 12'sh1EA && VALVE_POS_IN <= 12'sh1FE), 12'h001);
        wr(12'h000, 2'h0);
        tick(80);
        chk(VALVE_POS_IN, 12'h000);
        close_out();
    end
endmodule
`default_nettype wire
